// >>> audio_bitstream_converter_pkg.sv
// Purpose: Shared constants for the audio bitstream converter register block.
// Assumes: 32-bit register port, byte offsets as printed.
// Notes:   Field positions refer to 32-bit register words.
package audio_bitstream_converter_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] AUDIO_BITSTREAM_CONVERTER_OFS_SAMPLE_DATA  = 8'h00;
  localparam logic [7:0] AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL      = 8'h08;
  localparam logic [7:0] AUDIO_BITSTREAM_CONVERTER_OFS_INT_MASK     = 8'h0c;
  localparam logic [7:0] AUDIO_BITSTREAM_CONVERTER_OFS_INT_EN_SET   = 8'h10;
  localparam logic [7:0] AUDIO_BITSTREAM_CONVERTER_OFS_INT_DISABLE  = 8'h14;
  localparam logic [7:0] AUDIO_BITSTREAM_CONVERTER_OFS_STATUS_CLEAR = 8'h18;
  localparam logic [7:0] AUDIO_BITSTREAM_CONVERTER_OFS_INT_STATUS   = 8'h1c;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int AUDIO_BITSTREAM_CONVERTER_CTL_ENABLE_BIT   = 31;
  localparam int AUDIO_BITSTREAM_CONVERTER_CTL_SWAP_BIT     = 30;
  localparam int AUDIO_BITSTREAM_CONVERTER_READY_BIT        = 29;
  localparam int AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT     = 28;
  localparam int AUDIO_BITSTREAM_CONVERTER_RIGHT_LSB        = 16;
  localparam int AUDIO_BITSTREAM_CONVERTER_SAMPLE_W         = 16;
  localparam logic [31:0] AUDIO_BITSTREAM_CONVERTER_RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int AUDIO_BITSTREAM_CONVERTER_CONV_PER_SAMPLE  = 256;
  localparam int AUDIO_BITSTREAM_CONVERTER_CONV_DIV_DEFAULT = 1;

endpackage : audio_bitstream_converter_pkg

// >>> audio_bitstream_converter_modulator.sv
// Purpose: One-channel first-order bitstream modulator.
// Assumes: Advanced once per conversion tick.
// Notes:   A simple error-feedback loop stands in for the full filter chain.
`timescale 1ns/1ps
module audio_bitstream_converter_modulator
  import audio_bitstream_converter_pkg::*;
#(
  parameter int W = AUDIO_BITSTREAM_CONVERTER_SAMPLE_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] sample,
  output logic              bit_out,
  output logic              bit_out_n
);

  logic [W:0] acc_reg;
  logic [W:0] acc_next;

  // Offset binary turns the signed sample into a duty cycle.
  always_comb begin
    acc_next = {1'b0, acc_reg[W-1:0]} + {1'b0, ~sample[W-1], sample[W-2:0]};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg   <= '0;
      bit_out   <= 1'b0;
      bit_out_n <= 1'b1;
    end else if (!run) begin
      acc_reg   <= '0;
      bit_out   <= 1'b0;
      bit_out_n <= 1'b1;
    end else if (tick) begin
      acc_reg   <= acc_next;
      bit_out   <= acc_next[W];
      bit_out_n <= ~acc_next[W];
    end
  end

endmodule // audio_bitstream_converter_modulator

// >>> audio_bitstream_converter_regs.sv
// Purpose: Register port, status and interrupt logic of the bitstream converter.
// Assumes: Conversion clock is in phase with ref_clk, given as a tick enable.
// Notes:   One sample word is taken every CONV_PER_SAMPLE conversion ticks.
//
// What this block does
// - Channel 1 sample sits in bits 31:16 and channel 0 sample in bits 15:0 of the sample word.
// - Control bit 31 runs the converter; zero, the reset value, keeps it disabled.
// - Control bit 30 exchanges the two halves of each written sample word.
// - Ones written to the enable-set register set the matching mask bits.
// - Ones written to the disable register clear the matching mask bits.
// - Zeros written to enable-set, disable and status-clear change nothing.
// - A one written to status-clear bit 28 clears status bit 28 and its request; bit 29 is a live level and stays.
// - Status bit 29 is high exactly while a new sample word can be accepted.
// - Status bit 28 is set by any underrun and held until reset or a clear.
// - Reading the status register also clears status bit 28.
// - A ready request line lets a DMA channel feed samples with only enable set.
// - Each channel drives a bitstream and its inverse.
`timescale 1ns/1ps
module audio_bitstream_converter_regs
  import audio_bitstream_converter_pkg::*;
#(
  parameter int CONV_PER_SAMPLE = AUDIO_BITSTREAM_CONVERTER_CONV_PER_SAMPLE,
  parameter int CONV_DIV        = AUDIO_BITSTREAM_CONVERTER_CONV_DIV_DEFAULT
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic             dma_request,
  output logic [1:0]       bitstream_out,
  output logic [1:0]       bitstream_out_inverted
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic wr_sample;
  logic wr_control;
  logic wr_en_set;
  logic wr_disable;
  logic wr_clear;
  logic rd_status;

  assign wr_sample  = reg_write && (reg_addr == AUDIO_BITSTREAM_CONVERTER_OFS_SAMPLE_DATA);
  assign wr_control = reg_write && (reg_addr == AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL);
  assign wr_en_set  = reg_write && (reg_addr == AUDIO_BITSTREAM_CONVERTER_OFS_INT_EN_SET);
  assign wr_disable = reg_write && (reg_addr == AUDIO_BITSTREAM_CONVERTER_OFS_INT_DISABLE);
  assign wr_clear   = reg_write && (reg_addr == AUDIO_BITSTREAM_CONVERTER_OFS_STATUS_CLEAR);
  assign rd_status  = reg_read && (reg_addr == AUDIO_BITSTREAM_CONVERTER_OFS_INT_STATUS);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic enable_reg;
  logic swap_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= AUDIO_BITSTREAM_CONVERTER_RESET_WORD[AUDIO_BITSTREAM_CONVERTER_CTL_ENABLE_BIT];
      swap_reg   <= AUDIO_BITSTREAM_CONVERTER_RESET_WORD[AUDIO_BITSTREAM_CONVERTER_CTL_SWAP_BIT];
    end else if (wr_control) begin
      enable_reg <= reg_wdata[AUDIO_BITSTREAM_CONVERTER_CTL_ENABLE_BIT];
      swap_reg   <= reg_wdata[AUDIO_BITSTREAM_CONVERTER_CTL_SWAP_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Sample word holding register
  // ----------------------------------------------------------------------
  logic [31:0] sample_reg;
  logic        fresh_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_reg <= AUDIO_BITSTREAM_CONVERTER_RESET_WORD;
    end else if (wr_sample) begin
      if (swap_reg) begin
        sample_reg <= {reg_wdata[15:0], reg_wdata[31:16]};
      end else begin
        sample_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Conversion tick and sample period
  // ----------------------------------------------------------------------
  localparam int DIV_W = (CONV_DIV > 1) ? $clog2(CONV_DIV) : 1;
  localparam int PER_W = $clog2(CONV_PER_SAMPLE);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
  localparam logic [PER_W-1:0] PER_LAST = PER_W'(CONV_PER_SAMPLE - 1);

  logic [DIV_W-1:0] div_reg;
  logic [PER_W-1:0] period_reg;
  logic             tick;
  logic             take;

  assign tick = (div_reg == DIV_LAST);
  assign take = tick && (period_reg == PER_LAST);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (!enable_reg || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_reg <= '0;
    end else if (!enable_reg) begin
      period_reg <= '0;
    end else if (tick) begin
      period_reg <= period_reg + 1'b1;
    end
  end

  // Word in use by the modulators; reloaded at a period boundary only when a fresh word waits.
  logic [31:0] active_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= AUDIO_BITSTREAM_CONVERTER_RESET_WORD;
    end else if (take && fresh_reg) begin
      active_reg <= sample_reg;
    end
  end

  // Fresh marks an unconsumed written word; a write in the take cycle wins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fresh_reg <= 1'b0;
    end else if (wr_sample) begin
      fresh_reg <= 1'b1;
    end else if (take || !enable_reg) begin
      fresh_reg <= 1'b0;
    end
  end

  logic ready_now;
  logic underrun_ev;

  assign ready_now   = enable_reg && !fresh_reg;
  assign underrun_ev = take && !fresh_reg;
  assign dma_request = ready_now;

  // ----------------------------------------------------------------------
  // Mask and status
  // ----------------------------------------------------------------------
  logic mask_ready_reg;
  logic mask_under_reg;
  logic under_reg;
  logic under_clr;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ready_reg <= 1'b0;
      mask_under_reg <= 1'b0;
    end else begin
      if (wr_en_set && reg_wdata[AUDIO_BITSTREAM_CONVERTER_READY_BIT]) begin
        mask_ready_reg <= 1'b1;
      end else if (wr_disable && reg_wdata[AUDIO_BITSTREAM_CONVERTER_READY_BIT]) begin
        mask_ready_reg <= 1'b0;
      end
      if (wr_en_set && reg_wdata[AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT]) begin
        mask_under_reg <= 1'b1;
      end else if (wr_disable && reg_wdata[AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT]) begin
        mask_under_reg <= 1'b0;
      end
    end
  end

  assign under_clr = (wr_clear && reg_wdata[AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT]) || rd_status;

  // An underrun in the clearing cycle is kept: set wins over clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      under_reg <= 1'b0;
    end else if (underrun_ev) begin
      under_reg <= 1'b1;
    end else if (under_clr) begin
      under_reg <= 1'b0;
    end
  end

  // Ready is a live level, so a clear cannot hold it low while it is true.
  assign irq = (ready_now && mask_ready_reg) || (under_reg && mask_under_reg);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = '0;
    unique case (reg_addr)
      AUDIO_BITSTREAM_CONVERTER_OFS_SAMPLE_DATA: rdata_next = sample_reg;
      AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL: begin
        rdata_next[AUDIO_BITSTREAM_CONVERTER_CTL_ENABLE_BIT] = enable_reg;
        rdata_next[AUDIO_BITSTREAM_CONVERTER_CTL_SWAP_BIT]   = swap_reg;
      end
      AUDIO_BITSTREAM_CONVERTER_OFS_INT_MASK: begin
        rdata_next[AUDIO_BITSTREAM_CONVERTER_READY_BIT]    = mask_ready_reg;
        rdata_next[AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT] = mask_under_reg;
      end
      AUDIO_BITSTREAM_CONVERTER_OFS_INT_STATUS: begin
        rdata_next[AUDIO_BITSTREAM_CONVERTER_READY_BIT]    = ready_now;
        rdata_next[AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT] = under_reg;
      end
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Modulators, one per channel
  // ----------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      audio_bitstream_converter_modulator #(.W(AUDIO_BITSTREAM_CONVERTER_SAMPLE_W)) u_mod (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .run       (enable_reg),
        .tick      (tick),
        .sample    (active_reg[ch*AUDIO_BITSTREAM_CONVERTER_RIGHT_LSB +: AUDIO_BITSTREAM_CONVERTER_SAMPLE_W]),
        .bit_out   (bitstream_out[ch]),
        .bit_out_n (bitstream_out_inverted[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence clear_write_s;
    wr_clear && reg_wdata[AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT] && !underrun_ev;
  endsequence

  sequence enable_write_s;
    wr_en_set && reg_wdata[AUDIO_BITSTREAM_CONVERTER_READY_BIT];
  endsequence

  swap_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_sample && swap_reg |=> sample_reg == {$past(reg_wdata[15:0]), $past(reg_wdata[31:16])})
    else $error("swapped sample word wrong");
  plain_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_sample && !swap_reg |=> sample_reg == $past(reg_wdata))
    else $error("sample word not stored");
  disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !enable_reg |-> !dma_request && !ready_now)
    else $error("ready while disabled");
  mask_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    enable_write_s |=> mask_ready_reg)
    else $error("mask not set");
  mask_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_disable && reg_wdata[AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT] && !wr_en_set |=> !mask_under_reg)
    else $error("mask not cleared");
  zero_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en_set || wr_disable) && !reg_wdata[AUDIO_BITSTREAM_CONVERTER_READY_BIT] |=> $stable(mask_ready_reg))
    else $error("zero write changed mask");
  status_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clear_write_s |=> !under_reg)
    else $error("underrun not cleared");
  underrun_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    underrun_ev |=> under_reg)
    else $error("underrun not flagged");
  read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_status && !underrun_ev |=> !under_reg ##0 reg_rdata[AUDIO_BITSTREAM_CONVERTER_UNDERRUN_BIT] == $past(under_reg))
    else $error("status read did not clear");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq == ((ready_now && mask_ready_reg) || (under_reg && mask_under_reg)))
    else $error("interrupt level wrong");
  ready_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_sample |=> !ready_now)
    else $error("ready after write");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_read && reg_addr == AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL |=> reg_rdata[29:0] == 30'h0)
    else $error("reserved bits not zero");
  inverse_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bitstream_out == ~bitstream_out_inverted)
    else $error("outputs not complementary");

endmodule // audio_bitstream_converter_regs

// >>> audio_bitstream_converter_amp_model.sv
// Purpose: Far-side model of the amplifier or filter fed by the bitstream outputs.
// Assumes: Both pins of a channel are sampled on every rising edge of ref_clk.
// Notes:   The model only watches the pins, so it counts cycles in which a pin pair is not exactly inverse.
`timescale 1ns/1ps
module audio_bitstream_converter_amp_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] bitstream_out,
  input  wire logic [1:0] bitstream_out_inverted,
  output int              n_bad
);
  // --------------------------------------------------------------------
  // Differential input stage
  // --------------------------------------------------------------------
  // A differential stage only works if each pin pair is exactly inverse.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      n_bad <= 0;
    end else if (bitstream_out !== ~bitstream_out_inverted) begin
      n_bad <= n_bad + 1;
    end
  end
endmodule // audio_bitstream_converter_amp_model

// >>> audio_bitstream_dac_regs_tb_top.sv
// Purpose: Self-checking bench for the converter register block.
// Assumes: A short sample period of 8 ticks keeps the run brief.
// Notes:   Read expectations queue up and are checked when read data appear.
`timescale 1ns/1ps
module audio_bitstream_dac_regs_tb_top
  import audio_bitstream_converter_pkg::*;
;
  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        dma_request;
  logic [1:0]  bitstream_out;
  logic [1:0]  bitstream_out_inverted;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] w;
  logic        rd_pend;
  int          n_fail;
  int          tests_run;
  int          n_bad;
  logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

  audio_bitstream_converter_regs #(.CONV_PER_SAMPLE(8), .CONV_DIV(1)) audio_bitstream_converter_regs_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .dma_request(dma_request), .bitstream_out(bitstream_out),
    .bitstream_out_inverted(bitstream_out_inverted));

  audio_bitstream_converter_amp_model audio_bitstream_converter_amp_model_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .bitstream_out(bitstream_out),
    .bitstream_out_inverted(bitstream_out_inverted), .n_bad(n_bad));

  always #25 ref_clk = ~ref_clk;

  // --------------------------------------------------------------------
  // Checking and bus tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g,
                     input logic [31:0] m);
    tests_run++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Each access leaves one idle cycle so no strobe is set twice in a time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask

  task automatic wait_hi(input int sel);
    int k;
    k = 0;
    while (((sel == 0) ? dma_request : irq) !== 1'b1 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 200) begin
      n_fail++;
      $display("ERROR wait expected 1 seen 0");
      close_out();
    end
  endtask

  // Read data stand only in the cycle after the read and are zero otherwise.
  always @(posedge ref_clk) begin
    if (rd_pend === 1'b1) begin
      chk("reg_rdata", exp_q[0], reg_rdata, msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end else if (rst_n === 1'b1) begin
      chk("reg_rdata idle", 32'h0, reg_rdata, 32'hffff_ffff);
    end
    rd_pend <= reg_read;
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0; rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    reg_write = 1'b0; reg_read = 1'b0; rd_pend = 1'b0; n_fail = 0; tests_run = 0;
    w = $urandom(9343);
    repeat (2) @(posedge ref_clk);
    chk("bitstream_out", 32'h0, {30'h0, bitstream_out}, 32'h3);
    chk("bitstream_inv", 32'h3, {30'h0, bitstream_out_inverted}, 32'h3);
    chk("dma_request", 32'h0, {31'h0, dma_request}, 32'h1);
    rst_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0, 32'hffff_ffff);
    w = $urandom;
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h4000_0000 | (w & 32'h3fff_ffff));
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h4000_0000, 32'hffff_ffff);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_SAMPLE_DATA, w);
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_SAMPLE_DATA, {w[15:0], w[31:16]}, 32'hffff_ffff);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h0);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_SAMPLE_DATA, w);
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_SAMPLE_DATA, w, 32'hffff_ffff);
    #1 chk("dma_request", 32'h0, {31'h0, dma_request}, 32'h1);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_INT_EN_SET, 32'hffff_ffff);
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_INT_MASK, 32'h3000_0000, 32'hffff_ffff);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_INT_DISABLE, 32'h2000_0000);
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_INT_MASK, 32'h1000_0000, 32'hffff_ffff);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_INT_EN_SET, 32'h0);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_INT_DISABLE, 32'h0);
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_INT_MASK, 32'h1000_0000, 32'hffff_ffff);
    // No word is written, so the first sample period must end in an underrun.
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h8000_0000);
    wait_hi(1);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h0);
    #1 chk("irq", 32'h1, {31'h0, irq}, 32'h1);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_STATUS_CLEAR, 32'h2000_0000);
    #1 chk("irq", 32'h1, {31'h0, irq}, 32'h1);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_STATUS_CLEAR, 32'h1000_0000);
    #1 chk("irq", 32'h0, {31'h0, irq}, 32'h1);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h8000_0000);
    wait_hi(1);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h0);
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_INT_STATUS, 32'h1000_0000, 32'hffff_ffff);
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_INT_STATUS, 32'h0, 32'hffff_ffff);
    #1 chk("irq", 32'h0, {31'h0, irq}, 32'h1);
    // Feed words the way a DMA channel would, paced only by the request line.
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_INT_DISABLE, 32'hffff_ffff);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_INT_EN_SET, 32'h2000_0000);
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h8000_0000);
    for (int i = 0; i < 6; i++) begin
      // The request only drops after the write edge, so let that edge settle first.
      @(posedge ref_clk);
      wait_hi(0);
      #1 chk("irq", 32'h1, {31'h0, irq}, 32'h1);
      wr(AUDIO_BITSTREAM_CONVERTER_OFS_SAMPLE_DATA, $urandom);
    end
    wr(AUDIO_BITSTREAM_CONVERTER_OFS_CONTROL, 32'h0);
    rd(AUDIO_BITSTREAM_CONVERTER_OFS_INT_STATUS, 32'h0, 32'hffff_ffff);
    chk("complement", 32'h0, n_bad, 32'hffff_ffff);
    close_out();
  end
endmodule // audio_bitstream_dac_regs_tb_top
